// *** hdl/bpt_pkg.sv ***
// Package of register map, reset values, scale constants and carrier types for the bank.
package bpt_pkg;

   // ----------------------------------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_VOLT_ALARM = 6'h01;
   localparam logic [5:0] IDX_CUR_LIMIT  = 6'h02;
   localparam logic [5:0] IDX_CUR_ALARM  = 6'h03;
   localparam logic [5:0] IDX_CTRL       = 6'h30;
   localparam logic [5:0] IDX_STATUS     = 6'h31;

   localparam logic [7:0] ADDR_VOLT_ALARM = {IDX_VOLT_ALARM, 2'h0};
   localparam logic [7:0] ADDR_CUR_LIMIT  = {IDX_CUR_LIMIT, 2'h0};
   localparam logic [7:0] ADDR_CUR_ALARM  = {IDX_CUR_ALARM, 2'h0};
   localparam logic [7:0] ADDR_CTRL       = {IDX_CTRL, 2'h0};
   localparam logic [7:0] ADDR_STATUS     = {IDX_STATUS, 2'h0};

   // ----------------------------------------------------------------
   // Field positions and values after reset
   // ----------------------------------------------------------------
   localparam int unsigned DIS_BIT           = 7;
   localparam int unsigned CTRL_SOFT_RST_BIT = 0;
   localparam int unsigned CTRL_CLR_OFF_BIT  = 1;
   localparam int unsigned ST_VOLT_ALARM_BIT = 0;
   localparam int unsigned ST_CUR_ALARM_BIT  = 1;
   localparam int unsigned ST_CUR_LIMIT_BIT  = 2;
   localparam int unsigned ST_OUT_OFF_BIT    = 3;

   localparam logic [7:0] RST_VOLT_ALARM  = 8'h1C;
   localparam logic [7:0] RST_CUR_LIMIT   = 8'h3D;
   localparam logic [7:0] RST_CUR_ALARM   = 8'h3C;
   localparam logic [7:0] WMASK_VOLT_ALRM = 8'hBF;

   // ----------------------------------------------------------------
   // Threshold scaling, in millivolts and milliamperes
   // ----------------------------------------------------------------
   localparam logic [15:0] VOLT_BASE_MV = 16'h0DAC;
   localparam logic [15:0] VOLT_STEP_MV = 16'h0019;
   localparam logic [15:0] CUR_BASE_MA  = 16'h07D0;
   localparam logic [15:0] CUR_STEP_MA  = 16'h0064;
   localparam logic [15:0] CUR_CAP_MA   = 16'h2710;
   localparam logic [15:0] NO_CAP       = 16'hFFFF;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } bpt_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } bpt_apb_rsp_type;

   typedef struct packed {
      logic [15:0] vbat_mv;
      logic [15:0] ibat_ma;
   } bpt_meas_type;

endpackage

// *** hdl/bpt_code_to_level.sv ***
// Conversion of a threshold code into a level with an optional ceiling.
`timescale 1ns/1ps
module bpt_code_to_level #(
   parameter logic [15:0] BASE = 16'h0000,
   parameter logic [15:0] STEP = 16'h0001,
   parameter logic [15:0] CAP  = 16'hFFFF
) (
   input  wire logic [6:0]  code,
   output logic      [15:0] level
);
   logic [15:0] raw;

   // The largest code stays well inside sixteen bits, so no carry is lost.
   assign raw   = 16'(BASE + 16'(code) * STEP);
   assign level = (raw > CAP) ? CAP : raw;
endmodule

// *** hdl/bpt_cross_det.sv ***
// Registered detector of a measurement rising above a level.
`timescale 1ns/1ps
module bpt_cross_det (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [15:0] measure,
   input  wire logic [15:0] level,
   input  wire logic        inhibit,
   output logic             over_q
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         over_q <= 1'b0;
      end else begin
         over_q <= (measure > level) && !inhibit;
      end
   end
endmodule

// *** hdl/bpt_threshold_bank.sv ***
// Battery protection threshold bank with APB register access.
//
// Function
// - Voltage alarm is 3.5 V plus code times 25 mV.
// - Voltage above alarm level asserts interrupt low.
// - Voltage alarm code resets to 011100, 4.2 V.
// - Current limit is 2 A plus code times 100 mA.
// - Current limit saturates at 10 A.
// - Current above limit disables the power output.
// - Current limit code resets to 0111101, 8.1 A.
// - Current alarm 2 A plus 100 mA steps, default 8 A.
// - Current above alarm level asserts interrupt low.
// - Soft reset returns all threshold fields to defaults.
`timescale 1ns/1ps
module bpt_threshold_bank (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire bpt_pkg::bpt_apb_req_type apb_req,
   output logic                          psel_unused_n,
   output bpt_pkg::bpt_apb_rsp_type      apb_rsp,
   input  wire bpt_pkg::bpt_meas_type    meas,
   output logic                          int_n,
   output logic                          out_disable
);
   import bpt_pkg::*;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0]      volt_alarm_q;
   logic [7:0]      cur_limit_q;
   logic [7:0]      cur_alarm_q;
   logic            out_off_q;
   logic            int_n_q;
   logic            idle_q;
   bpt_apb_rsp_type rsp_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic        acc_phase;
   logic        done;
   logic        wr_en;
   logic        hit;
   logic [31:0] rd_data;
   logic        soft_rst;
   logic        clr_off;
   logic [3:0]  status;

   assign acc_phase = apb_req.psel && apb_req.penable;
   assign done      = acc_phase && rsp_q.pready;
   assign wr_en     = done && apb_req.pwrite && hit;
   assign soft_rst  = wr_en && (apb_req.paddr == ADDR_CTRL)
                      && apb_req.pwdata[CTRL_SOFT_RST_BIT];
   assign clr_off   = wr_en && (apb_req.paddr == ADDR_CTRL)
                      && apb_req.pwdata[CTRL_CLR_OFF_BIT];

   always_comb begin
      hit     = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (apb_req.paddr)
         ADDR_VOLT_ALARM: rd_data = {24'h00_0000, volt_alarm_q};
         ADDR_CUR_LIMIT:  rd_data = {24'h00_0000, cur_limit_q};
         ADDR_CUR_ALARM:  rd_data = {24'h00_0000, cur_alarm_q};
         ADDR_CTRL:       rd_data = 32'h0000_0000;
         ADDR_STATUS:     rd_data = {28'h000_0000, status};
         default:         hit     = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // The answer is registered, so every access phase lasts two cycles.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_q <= '0;
      end else begin
         rsp_q.pready <= acc_phase && !rsp_q.pready;
         if (acc_phase && !rsp_q.pready) begin
            rsp_q.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
            rsp_q.pslverr <= !hit;
         end else begin
            rsp_q.pslverr <= 1'b0;
         end
      end
   end

   assign apb_rsp = rsp_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_q <= 1'b1;
      end else begin
         idle_q <= !apb_req.psel;
      end
   end

   assign psel_unused_n = idle_q;

   // ----------------------------------------------------------------
   // Threshold registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         volt_alarm_q <= RST_VOLT_ALARM;
      end else if (soft_rst) begin
         volt_alarm_q <= RST_VOLT_ALARM;
      end else if (wr_en && apb_req.paddr == ADDR_VOLT_ALARM) begin
         volt_alarm_q <= apb_req.pwdata[7:0] & WMASK_VOLT_ALRM;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_limit_q <= RST_CUR_LIMIT;
      end else if (soft_rst) begin
         cur_limit_q <= RST_CUR_LIMIT;
      end else if (wr_en && apb_req.paddr == ADDR_CUR_LIMIT) begin
         cur_limit_q <= apb_req.pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_alarm_q <= RST_CUR_ALARM;
      end else if (soft_rst) begin
         cur_alarm_q <= RST_CUR_ALARM;
      end else if (wr_en && apb_req.paddr == ADDR_CUR_ALARM) begin
         cur_alarm_q <= apb_req.pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Levels and crossing detectors
   // ----------------------------------------------------------------
   // Channel 0 is the voltage alarm, 1 the current limit, 2 the current alarm.
   localparam logic [15:0] BASE_TAB [3] = '{VOLT_BASE_MV, CUR_BASE_MA, CUR_BASE_MA};
   localparam logic [15:0] STEP_TAB [3] = '{VOLT_STEP_MV, CUR_STEP_MA, CUR_STEP_MA};
   localparam logic [15:0] CAP_TAB  [3] = '{NO_CAP, CUR_CAP_MA, NO_CAP};

   logic [6:0]  code_arr  [3];
   logic [15:0] meas_arr  [3];
   logic [15:0] level_arr [3];
   logic        inh_arr   [3];
   logic        over_arr  [3];

   assign code_arr[0] = {1'b0, volt_alarm_q[5:0]};
   assign code_arr[1] = cur_limit_q[6:0];
   assign code_arr[2] = cur_alarm_q[6:0];
   assign meas_arr[0] = meas.vbat_mv;
   assign meas_arr[1] = meas.ibat_ma;
   assign meas_arr[2] = meas.ibat_ma;
   assign inh_arr[0]  = volt_alarm_q[DIS_BIT];
   assign inh_arr[1]  = cur_limit_q[DIS_BIT];
   assign inh_arr[2]  = cur_alarm_q[DIS_BIT];

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : g_chan
         // Scale and offset per channel; only the limit channel is capped.
         bpt_code_to_level #(
            .BASE (BASE_TAB[ch]),
            .STEP (STEP_TAB[ch]),
            .CAP  (CAP_TAB[ch])
         ) u_level (
            .code  (code_arr[ch]),
            .level (level_arr[ch])
         );

         bpt_cross_det u_det (
            .pclk    (pclk),
            .presetn (presetn),
            .measure (meas_arr[ch]),
            .level   (level_arr[ch]),
            .inhibit (inh_arr[ch]),
            .over_q  (over_arr[ch])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Interrupt and output shutdown
   // ----------------------------------------------------------------
   // The request is a level that follows the alarms; latching and masking
   // live in the flag registers outside this bank.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_n_q <= 1'b1;
      end else begin
         int_n_q <= !(over_arr[0] || over_arr[2]);
      end
   end

   // Shutdown stays latched so a current spike cannot re-enable the stage;
   // a new crossing in the clearing cycle wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_off_q <= 1'b0;
      end else if (over_arr[1]) begin
         out_off_q <= 1'b1;
      end else if (clr_off || soft_rst) begin
         out_off_q <= 1'b0;
      end
   end

   assign int_n       = int_n_q;
   assign out_disable = out_off_q;

   always_comb begin
      status                    = 4'h0;
      status[ST_VOLT_ALARM_BIT] = over_arr[0];
      status[ST_CUR_ALARM_BIT]  = over_arr[2];
      status[ST_CUR_LIMIT_BIT]  = over_arr[1];
      status[ST_OUT_OFF_BIT]    = out_off_q;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence

   sequence s_access;
      apb_req.psel && apb_req.penable && !rsp_q.pready;
   endsequence

   property p_apb_answer;
      s_setup ##1 s_access |=> apb_rsp.pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("APB answer not given one cycle into access.");

   property p_volt_level;
      level_arr[0] == 16'(VOLT_BASE_MV + 16'(volt_alarm_q[5:0]) * VOLT_STEP_MV);
   endproperty
   a_volt_level: assert property (p_volt_level)
      else $error("Voltage alarm level does not match its code.");

   property p_volt_int;
      (meas.vbat_mv > level_arr[0]) && !volt_alarm_q[DIS_BIT] |-> ##2 !int_n;
   endproperty
   a_volt_int: assert property (p_volt_int)
      else $error("Voltage alarm crossing did not pull the interrupt low.");

   property p_volt_soft;
      // Code 28 on the 25 mV scale lands at 4.2 V, so the level follows the scale.
      soft_rst |=> volt_alarm_q == RST_VOLT_ALARM && level_arr[0] == 16'h1068;
   endproperty
   a_volt_soft: assert property (p_volt_soft)
      else $error("Voltage alarm did not return to its default code.");

   property p_lim_level;
      cur_limit_q[6:0] <= 7'h50 |->
         level_arr[1] == 16'(CUR_BASE_MA + 16'(cur_limit_q[6:0]) * CUR_STEP_MA);
   endproperty
   a_lim_level: assert property (p_lim_level)
      else $error("Current limit level does not match its code.");

   property p_lim_cap;
      cur_limit_q[6:0] > 7'h50 |-> level_arr[1] == 16'h2710;
   endproperty
   a_lim_cap: assert property (p_lim_cap)
      else $error("Current limit not held at 10 A.");

   property p_lim_off;
      (meas.ibat_ma > level_arr[1]) && !cur_limit_q[DIS_BIT] |-> ##2 out_disable;
   endproperty
   a_lim_off: assert property (p_lim_off)
      else $error("Overcurrent did not disable the output.");

   property p_lim_soft;
      soft_rst |=> cur_limit_q == 8'h3D && level_arr[1] == 16'h1FA4;
   endproperty
   a_lim_soft: assert property (p_lim_soft)
      else $error("Current limit did not return to its 8.1 A default.");

   property p_alm_soft;
      soft_rst |=> cur_alarm_q == 8'h3C && level_arr[2] == 16'h1F40;
   endproperty
   a_alm_soft: assert property (p_alm_soft)
      else $error("Current alarm did not return to its 8 A default.");

   property p_alm_int;
      (meas.ibat_ma > level_arr[2]) && !cur_alarm_q[DIS_BIT] |-> ##2 !int_n;
   endproperty
   a_alm_int: assert property (p_alm_int)
      else $error("Current alarm crossing did not pull the interrupt low.");

   sequence s_both_alarms_off;
      (volt_alarm_q[DIS_BIT] && cur_alarm_q[DIS_BIT]) [*3];
   endsequence

   property p_alarm_disable;
      s_both_alarms_off |-> int_n;
   endproperty
   a_alarm_disable: assert property (p_alarm_disable)
      else $error("Interrupt asserted while both alarms are disabled.");

   property p_off_hold;
      out_disable && !clr_off && !soft_rst |=> out_disable;
   endproperty
   a_off_hold: assert property (p_off_hold)
      else $error("Output shutdown released without a clear.");

   property p_alm_level;
      level_arr[2] == 16'(CUR_BASE_MA + 16'(cur_alarm_q[6:0]) * CUR_STEP_MA);
   endproperty
   a_alm_level: assert property (p_alm_level)
      else $error("Current alarm level does not match its code.");

   property p_int_clear;
      !over_arr[0] && !over_arr[2] |=> int_n;
   endproperty
   a_int_clear: assert property (p_int_clear)
      else $error("Interrupt held low with no alarm crossing.");

   sequence s_limit_off;
      cur_limit_q[DIS_BIT] [*2];
   endsequence

   property p_limit_disable;
      s_limit_off |-> !over_arr[1];
   endproperty
   a_limit_disable: assert property (p_limit_disable)
      else $error("Current limit crossing seen while the limit is disabled.");

   property p_rsp_quiet;
      !acc_phase |=> !apb_rsp.pready && !apb_rsp.pslverr;
   endproperty
   a_rsp_quiet: assert property (p_rsp_quiet)
      else $error("APB answer given outside an access phase.");

   property p_unmapped_err;
      s_access ##0 !hit |=> apb_rsp.pready && apb_rsp.pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("Unmapped access did not report an error.");

endmodule

// *** sim/bpt_host_model.sv ***
// Host side model: an APB master that programs the threshold bank.
`timescale 1ns/1ps
module bpt_host_model (
   input  wire logic                     pclk,
   output bpt_pkg::bpt_apb_req_type      apb_req,
   input  wire bpt_pkg::bpt_apb_rsp_type apb_rsp
);
   import bpt_pkg::*;
   initial apb_req = '0;
   // Ready and data are taken at the rising edge that completes the transfer.
   // There is no wait limit here; the bench's cycle ceiling ends a hung transfer.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
endmodule

// *** sim/bpt_threshold_bank_test.sv ***
// Self-checking bench for the battery protection threshold bank.
`timescale 1ns/1ps
module bpt_threshold_bank_test;
   import bpt_pkg::*;
   logic            pclk = 1'b0;
   logic            presetn = 1'b0;
   bpt_apb_req_type apb_req;
   bpt_apb_rsp_type apb_rsp;
   bpt_meas_type    meas = '0;
   logic            psel_unused_n;
   logic            int_n;
   logic            out_disable;
   logic [31:0]     q;
   logic            err;
   int              num_errors = 0;
   int              cmp_count = 0;
   int              seed = 42;
   int              cycles = 0;
   int              regs [3];
   int              od = 0;
   bit              psel_seen = 1'b0;

   always #4 pclk = ~pclk;

   bpt_threshold_bank i_bpt_threshold_bank (.pclk(pclk), .presetn(presetn),
      .apb_req(apb_req), .psel_unused_n(psel_unused_n), .apb_rsp(apb_rsp),
      .meas(meas), .int_n(int_n), .out_disable(out_disable));
   bpt_host_model i_bpt_host_model (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

   function automatic int vlvl(int c);
      return 3500 + 25 * (c % 64);
   endfunction
   function automatic int clvl(int c, bit cap);
      int l;
      l = 2000 + 100 * (c % 128);
      return (cap && l > 10000) ? 10000 : l;
   endfunction

   task automatic check_word(string what, logic [31:0] exp, logic [31:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_bit(string what, logic exp, logic seen);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %b seen %b", what, exp, seen);
      end
   endtask

   // The mirror follows every write; bit 6 of the voltage alarm is reserved.
   // A clear or soft reset loses to a limit crossing that is still present.
   task automatic wr(logic [7:0] a, logic [31:0] d);
      int hold;
      hold = (regs[1] < 128 && meas.ibat_ma > clvl(regs[1], 1));
      i_bpt_host_model.xfer(1'b1, a, d, q, err);
      if (a == 8'h04) regs[0] = int'(d & 32'hBF);
      if (a == 8'h08 || a == 8'h0C) regs[a / 4 - 1] = int'(d & 32'hFF);
      if (a == ADDR_CTRL && d[0]) regs = '{28, 61, 60};
      if (a == ADDR_CTRL && d[1:0] != 2'h0) od = hold;
   endtask
   task automatic rd(logic [7:0] a, int exp, bit bad);
      i_bpt_host_model.xfer(1'b0, a, 32'h0, q, err);
      check_word("prdata", exp, q);
      check_bit("pslverr", bad, err);
   endtask

   // A set crossing wins over a clear in the same cycle, so the latch is updated last.
   task automatic apply(int v, int i);
      int va, ca, cl;
      meas <= '{16'(v), 16'(i)};
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      va = (regs[0] < 128 && v > vlvl(regs[0]));
      ca = (regs[2] < 128 && i > clvl(regs[2], 0));
      cl = (regs[1] < 128 && i > clvl(regs[1], 1));
      od = od | cl;
      check_bit("int_n", !(va || ca), int_n);
      check_bit("out_disable", od[0], out_disable);
      rd(ADDR_STATUS, od * 8 + cl * 4 + ca * 2 + va, 0);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // The idle indicator shows the select seen at the previous edge, inverted.
   always @(posedge pclk) psel_seen <= apb_req.psel;
   always @(negedge pclk) begin
      if (presetn) check_bit("psel_unused_n", !psel_seen, psel_unused_n);
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      int c, l;
      regs = '{28, 61, 60};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_VOLT_ALARM, 8'h1C, 0);
      rd(ADDR_CUR_LIMIT, 8'h3D, 0);
      rd(ADDR_CUR_ALARM, 8'h3C, 0);
      $display("test reset values done");
      wr(8'h40, 32'hFF);
      rd(8'h40, 0, 1);
      rd(ADDR_CTRL, 0, 0);
      $display("test unmapped done");
      for (int k = 0; k < 12; k++) begin
         wr(8'(4 * (1 + k % 3)), $random(seed));
         rd(8'(4 * (1 + k % 3)), regs[k % 3], 0);
      end
      $display("test readback done");
      for (int k = 0; k < 5; k++) begin
         c = (k == 0) ? 0 : (k == 1) ? 63 : $random(seed) & 63;
         wr(ADDR_VOLT_ALARM, c);
         apply(vlvl(c), 0);
         apply(vlvl(c) + 1, 0);
      end
      apply(0, 0);
      $display("test voltage alarm done");
      for (int k = 0; k < 3; k++) begin
         c = $random(seed) & 31;
         l = c + 1 + ($random(seed) & 15);
         wr(ADDR_CUR_ALARM, c);
         wr(ADDR_CUR_LIMIT, l);
         apply(0, clvl(c, 0));
         apply(0, clvl(c, 0) + 1);
         apply(0, clvl(l, 1) + 1);
         apply(0, 0);
         wr(ADDR_CTRL, 32'h2);
         apply(0, 0);
      end
      $display("test current thresholds done");
      wr(ADDR_CUR_ALARM, 32'h80);
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_CUR_LIMIT, 80 + ($random(seed) & 47));
         apply(0, 10000);
         apply(0, 10001);
         apply(0, 0);
         wr(ADDR_CTRL, 32'h2);
      end
      $display("test saturation done");
      wr(ADDR_VOLT_ALARM, 32'h80);
      wr(ADDR_CUR_LIMIT, 32'h80);
      apply(65535, 65535);
      $display("test disable done");
      apply(0, 0);
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_VOLT_ALARM, 8'h1C, 0);
      rd(ADDR_CUR_LIMIT, 8'h3D, 0);
      rd(ADDR_CUR_ALARM, 8'h3C, 0);
      apply(4001, 0);
      apply(4201, 0);
      apply(0, 8001);
      apply(0, 8101);
      wr(ADDR_CTRL, 32'h1);
      apply(0, 0);
      wr(ADDR_CTRL, 32'h1);
      apply(0, 0);
      $display("test soft reset done");
      tally_and_finish();
   end
endmodule
